/* File: cfsr_map.svh */
`ifndef CFSR_MAP_SVH
`define CFSR_MAP_SVH
`define CFSR_WORD_W 16
`define CFSR_SEL_GAIN 2'h0
`define CFSR_SEL_MODE 2'h1
`define CFSR_SEL_CLAMP 2'h2
`define CFSR_SEL_TEST 2'h3
`define CFSR_GAIN_LSB 2
`define CFSR_GAIN_MSB 12
`define CFSR_GAIN_STANDBY_SELECT 15
`define CFSR_MODE_SPINV 2
`define CFSR_MODE_OBPOL 3
`define CFSR_MODE_CLKRNG 4
`define CFSR_MODE_OFSEN 5
`define CFSR_MODE_OFS_LSB 6
`define CFSR_MODE_OFS_MSB 9
`define CFSR_MODE_LOW_BIT_INVERT_SELECT 10
`define CFSR_MODE_HINV 11
`define CFSR_MODE_OTEST 12
`define CFSR_MODE_RUN 13
`define CFSR_MODE_CAL 14
`define CFSR_MODE_SLEEP 15
`define CFSR_CLAMP_LSB 2
`define CFSR_CLAMP_MSB 6
`define CFSR_RST_WORD 16'h0000
`define CFSR_CNT_W 5
`define CFSR_CNT_LAST 5'h0F
`define CFSR_CNT_FULL 5'h10
`define CFSR_CNT_RST 5'h00
`define CFSR_SYNC_RST 6'h00
`define CFSR_CLAMP_RST 5'h00
`define CFSR_SOFT_RST_ON 1'b1
`endif

/* File: cfsr_pkg.sv */
package cfsr_pkg;
   typedef struct packed {
      logic standby_select;
      logic [10:0] gain_code;
   } cfsr_gain_t;
   typedef struct packed {
      logic sleep_select;
      logic offset_calibration_mode;
      logic run_enable;
      logic output_test_select;
      logic high_bit_invert_select;
      logic low_bit_invert_select;
      logic [3:0] ccd_offset_setting;
      logic offset_cancel_enable;
      logic clock_range_select;
      logic black_pulse_polarity;
      logic sample_pulse_invert;
   } cfsr_mode_t;
   typedef struct packed {
      logic sck;
      logic sen;
      logic serial_data_line;
   } cfsr_link_t;
endpackage

/* File: cfsr_regs.sv */
// Behaviour
// - Gain word bits 12:2 hold the 11-bit amplifier gain code.
// - Gain word bit 15 selects standby.
// - Mode bit 2 inverts signal and black sample pulse polarity.
// - Mode bit 3 sets optical black pulse polarity, 1 active high.
// - Mode bit 4 selects clock range, 1 below 10MHz.
// - Mode bit 5 enables CCD offset cancel.
// - Mode bits 9:6 hold the 4-bit CCD offset setting.
// - Mode bits 10, 11, 12 are low invert, high invert, output test.
// - Mode bit 13 low holds the device in soft reset.
// - Mode bit 14 selects offset-cancel calibration mode.
// - Mode bit 15 selects sleep mode.
// - Clamp word bits 6:2 hold the 5-bit clamp level.
`timescale 1ns/100ps
`include "cfsr_map.svh"
module cfsr_regs (
   input wire logic clk,
   input wire logic rstn,
   input wire cfsr_pkg::cfsr_link_t link_in,
   input wire logic signal_sample_pulse,
   input wire logic black_sample_pulse,
   input wire logic optical_black_pulse,
   output logic [15:0] gain_word,
   output logic [15:0] mode_control_word,
   output logic [15:0] clamp_word,
   output logic [15:0] factory_test_word,
   output cfsr_pkg::cfsr_gain_t gain_out,
   output cfsr_pkg::cfsr_mode_t mode_out,
   output logic [4:0] clamp_level,
   output logic soft_reset_active,
   output logic sleep_active,
   output logic signal_sample_active,
   output logic black_sample_active,
   output logic optical_black_active
);
   import cfsr_pkg::*;

   // Two-flop synchronisers on every link and pulse pin; rstn is used unsynchronised.
   logic [5:0] s1_r;
   logic [5:0] s1_nxt;
   logic [5:0] s2_r;
   logic [5:0] s2_nxt;
   logic sck_d_r;
   logic sck_d_nxt;
   logic sck_s;
   logic sen_s;
   logic serial_data_line_s;
   logic sig_s;
   logic blk_s;
   logic obp_s;

   // Serial shift state.
   logic [15:0] shift_r;
   logic [15:0] shift_nxt;
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   logic word_ok_r;
   logic word_ok_nxt;
   logic sck_rise;

   // Register slots, indexed by the select code.
   wire logic [3:0][15:0] word_q;

   // Next values of the outputs.
   logic [15:0] gain_word_nxt;
   logic [15:0] mode_control_word_nxt;
   logic [15:0] clamp_word_nxt;
   logic [15:0] factory_test_word_nxt;
   cfsr_gain_t gain_out_nxt;
   cfsr_mode_t mode_out_nxt;
   logic [4:0] clamp_level_nxt;
   logic soft_reset_active_nxt;
   logic sleep_active_nxt;
   logic signal_sample_active_nxt;
   logic black_sample_active_nxt;
   logic optical_black_active_nxt;

   // Compares a select code with the number of a slot.
   function automatic logic slot_hit(input logic [1:0] sel, input logic [1:0] slot);
      return sel == slot;
   endfunction

   // Gives the active level of a pulse pin after an optional flip.
   function automatic logic pulse_level(input logic pin, input logic flip);
      return pin ^ flip;
   endfunction

   always_comb begin
      s1_nxt = {link_in.sck, link_in.sen, link_in.serial_data_line,
                signal_sample_pulse, black_sample_pulse, optical_black_pulse};
      s2_nxt = s1_r;
      sck_d_nxt = sck_s;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s1_r <= `CFSR_SYNC_RST;
         s2_r <= `CFSR_SYNC_RST;
         sck_d_r <= 1'b0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         sck_d_r <= sck_d_nxt;
      end
   end

   // Only the second stage is read beyond this point.
   assign sck_s = s2_r[5];
   assign sen_s = s2_r[4];
   assign serial_data_line_s = s2_r[3];
   assign sig_s = s2_r[2];
   assign blk_s = s2_r[1];
   assign obp_s = s2_r[0];

   // Bits shift in MSB first on link clock rises while enable is high.
   // Rises after the sixteenth are ignored; a full word is kept when enable falls.
   always_comb begin
      sck_rise = sck_s & ~sck_d_r;
      shift_nxt = shift_r;
      cnt_nxt = cnt_r;
      word_ok_nxt = 1'b0;
      if (!sen_s) begin
         cnt_nxt = `CFSR_CNT_RST;
         word_ok_nxt = (cnt_r == `CFSR_CNT_FULL);
      end else if (sck_rise && cnt_r != `CFSR_CNT_FULL) begin
         shift_nxt = {shift_r[14:0], serial_data_line_s};
         cnt_nxt = cnt_r + 5'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         shift_r <= `CFSR_RST_WORD;
         cnt_r <= `CFSR_CNT_RST;
         word_ok_r <= 1'b0;
      end else begin
         shift_r <= shift_nxt;
         cnt_r <= cnt_nxt;
         word_ok_r <= word_ok_nxt;
      end
   end

   for (genvar i = 0; i < 4; i++) begin : g_slot
      logic [15:0] slot_r;
      logic [15:0] slot_nxt;

      always_comb begin
         slot_nxt = slot_r;
         if (word_ok_r && slot_hit(shift_r[1:0], 2'(i))) begin
            slot_nxt = shift_r;
         end
      end

      always_ff @(posedge clk) begin
         if (!rstn) begin
            slot_r <= `CFSR_RST_WORD;
         end else begin
            slot_r <= slot_nxt;
         end
      end

      assign word_q[i] = slot_r;
   end

   // Registered copies of the four words.
   always_comb begin
      gain_word_nxt = word_q[`CFSR_SEL_GAIN];
      mode_control_word_nxt = word_q[`CFSR_SEL_MODE];
      clamp_word_nxt = word_q[`CFSR_SEL_CLAMP];
      factory_test_word_nxt = word_q[`CFSR_SEL_TEST];
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         gain_word <= `CFSR_RST_WORD;
         mode_control_word <= `CFSR_RST_WORD;
         clamp_word <= `CFSR_RST_WORD;
         factory_test_word <= `CFSR_RST_WORD;
      end else begin
         gain_word <= gain_word_nxt;
         mode_control_word <= mode_control_word_nxt;
         clamp_word <= clamp_word_nxt;
         factory_test_word <= factory_test_word_nxt;
      end
   end

   // Gain word fields.
   always_comb begin
      gain_out_nxt.gain_code = word_q[`CFSR_SEL_GAIN][`CFSR_GAIN_MSB:`CFSR_GAIN_LSB];
      gain_out_nxt.standby_select = word_q[`CFSR_SEL_GAIN][`CFSR_GAIN_STANDBY_SELECT];
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         gain_out <= '0;
      end else begin
         gain_out <= gain_out_nxt;
      end
   end

   // Mode word fields.
   always_comb begin
      mode_out_nxt.sample_pulse_invert = word_q[`CFSR_SEL_MODE][`CFSR_MODE_SPINV];
      mode_out_nxt.black_pulse_polarity = word_q[`CFSR_SEL_MODE][`CFSR_MODE_OBPOL];
      mode_out_nxt.clock_range_select = word_q[`CFSR_SEL_MODE][`CFSR_MODE_CLKRNG];
      mode_out_nxt.offset_cancel_enable = word_q[`CFSR_SEL_MODE][`CFSR_MODE_OFSEN];
      mode_out_nxt.ccd_offset_setting =
         word_q[`CFSR_SEL_MODE][`CFSR_MODE_OFS_MSB:`CFSR_MODE_OFS_LSB];
      mode_out_nxt.low_bit_invert_select = word_q[`CFSR_SEL_MODE][`CFSR_MODE_LOW_BIT_INVERT_SELECT];
      mode_out_nxt.high_bit_invert_select = word_q[`CFSR_SEL_MODE][`CFSR_MODE_HINV];
      mode_out_nxt.output_test_select = word_q[`CFSR_SEL_MODE][`CFSR_MODE_OTEST];
      mode_out_nxt.run_enable = word_q[`CFSR_SEL_MODE][`CFSR_MODE_RUN];
      mode_out_nxt.offset_calibration_mode = word_q[`CFSR_SEL_MODE][`CFSR_MODE_CAL];
      mode_out_nxt.sleep_select = word_q[`CFSR_SEL_MODE][`CFSR_MODE_SLEEP];
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         mode_out <= '0;
      end else begin
         mode_out <= mode_out_nxt;
      end
   end

   // Mode levels driven to the rest of the chip.
   always_comb begin
      soft_reset_active_nxt = ~word_q[`CFSR_SEL_MODE][`CFSR_MODE_RUN];
      sleep_active_nxt = word_q[`CFSR_SEL_MODE][`CFSR_MODE_SLEEP];
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         soft_reset_active <= `CFSR_SOFT_RST_ON;
         sleep_active <= 1'b0;
      end else begin
         soft_reset_active <= soft_reset_active_nxt;
         sleep_active <= sleep_active_nxt;
      end
   end

   // Clamp word field.
   always_comb begin
      clamp_level_nxt = word_q[`CFSR_SEL_CLAMP][`CFSR_CLAMP_MSB:`CFSR_CLAMP_LSB];
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         clamp_level <= `CFSR_CLAMP_RST;
      end else begin
         clamp_level <= clamp_level_nxt;
      end
   end

   // Sample pulse pins after polarity selection.
   always_comb begin
      signal_sample_active_nxt = pulse_level(sig_s, word_q[`CFSR_SEL_MODE][`CFSR_MODE_SPINV]);
      black_sample_active_nxt = pulse_level(blk_s, word_q[`CFSR_SEL_MODE][`CFSR_MODE_SPINV]);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         signal_sample_active <= 1'b0;
         black_sample_active <= 1'b0;
      end else begin
         signal_sample_active <= signal_sample_active_nxt;
         black_sample_active <= black_sample_active_nxt;
      end
   end

   // Optical black pin after polarity selection.
   always_comb begin
      optical_black_active_nxt = pulse_level(obp_s, ~word_q[`CFSR_SEL_MODE][`CFSR_MODE_OBPOL]);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         optical_black_active <= 1'b0;
      end else begin
         optical_black_active <= optical_black_active_nxt;
      end
   end
endmodule

/* File: cfsr_ctl.sv */
`timescale 1ns/100ps
module cfsr_ctl (
   input wire logic clk,
   output cfsr_pkg::cfsr_link_t link
);
   import cfsr_pkg::*;
   initial link = '0;
   task automatic send(input logic [15:0] w, input int n);
      link.sen = 1'b1;
      for (int i = 15; i > 15 - n; i--) begin
         link.serial_data_line = w[i];
         repeat (4) @(negedge clk);
         link.sck = 1'b1;
         repeat (4) @(negedge clk);
         link.sck = 1'b0;
      end
      link.sen = 1'b0;
      link.serial_data_line = ~link.serial_data_line;
      repeat (8) @(negedge clk);
   endtask
endmodule

/* File: cfsr_regs_chk.sv */
`timescale 1ns/100ps
module cfsr_regs_chk (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [15:0] gain_word,
   input wire logic [15:0] mode_control_word,
   input wire logic [15:0] clamp_word,
   input wire cfsr_pkg::cfsr_gain_t gain_out,
   input wire cfsr_pkg::cfsr_mode_t mode_out,
   input wire logic [4:0] clamp_level,
   input wire logic soft_reset_active,
   input wire logic sleep_active
);
   import cfsr_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_rt_gain; gain_word[1:0] == 2'h0; endproperty
   property p_rt_mode; mode_control_word != 16'h0000 |-> mode_control_word[1:0] == 2'h1;
   endproperty
   property p_rt_clamp; clamp_word != 16'h0000 |-> clamp_word[1:0] == 2'h2; endproperty
   property p_gain; $stable(gain_word) |-> gain_out == {gain_word[15], gain_word[12:2]};
   endproperty
   property p_mode; $stable(mode_control_word) |-> mode_out == mode_control_word[15:2];
   endproperty
   property p_run; $stable(mode_control_word) |-> soft_reset_active == !mode_control_word[13];
   endproperty
   property p_sleep; $stable(mode_control_word) |-> sleep_active == mode_control_word[15];
   endproperty
   property p_clamp; $stable(clamp_word) |-> clamp_level == clamp_word[6:2]; endproperty
   a_rt_gain: assert property (p_rt_gain) else $error("gain word select bits wrong");
   a_rt_mode: assert property (p_rt_mode) else $error("mode word select bits wrong");
   a_rt_clamp: assert property (p_rt_clamp) else $error("clamp word select wrong");
   a_gain: assert property (p_gain) else $error("gain fields wrong");
   a_mode: assert property (p_mode) else $error("mode fields wrong");
   a_run: assert property (p_run) else $error("soft reset output wrong");
   a_sleep: assert property (p_sleep) else $error("sleep output wrong");
   a_clamp: assert property (p_clamp) else $error("clamp level wrong");
   c_cal: cover property ($rose(mode_out.offset_calibration_mode));
   c_run: cover property ($fell(soft_reset_active));
   c_standby_select: cover property ($rose(gain_out.standby_select));
endmodule
bind cfsr_regs cfsr_regs_chk i_cfsr_regs_chk (.*);

/* File: tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   import cfsr_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   cfsr_link_t link;
   logic [15:0] gw, mw, cw, tw, w;
   cfsr_gain_t go;
   cfsr_mode_t mo;
   logic [4:0] cl;
   logic sra, sla, ssa, bsa, oba;
   logic sp_sig = 1'b0;
   logic sp_blk = 1'b0;
   logic ob_pin = 1'b0;
   int error_cnt = 0;
   int comparisons = 0;
   always #20 clk = ~clk;
   cfsr_ctl i_cfsr_ctl (.clk(clk), .link(link));
   cfsr_regs i_cfsr_regs (.clk(clk), .rstn(rstn), .link_in(link), .signal_sample_pulse(sp_sig),
      .black_sample_pulse(sp_blk), .optical_black_pulse(ob_pin), .gain_word(gw),
      .mode_control_word(mw), .clamp_word(cw), .factory_test_word(tw), .gain_out(go),
      .mode_out(mo), .clamp_level(cl), .soft_reset_active(sra), .sleep_active(sla),
      .signal_sample_active(ssa), .black_sample_active(bsa), .optical_black_active(oba));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #3_000_000;
      error_cnt++;
      wrap_up();
   end
   initial begin
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      chk("words", 16'h0000, gw | mw | cw | tw);
      chk("soft_reset", 16'h0001, 16'(sra));
      i_cfsr_ctl.send(16'h0001, 16);
      chk("mode_word", 16'h0001, mw);
      i_cfsr_ctl.send(16'h2001, 16);
      chk("soft_reset", 16'h0000, 16'(sra));
      i_cfsr_ctl.send(16'hE87E, 16);
      chk("clamp_level", 16'h001F, 16'(cl));
      i_cfsr_ctl.send(16'h9FFC, 16);
      chk("gain_out", 16'h0FFF, 16'(go));
      $display("power-on test done");
      for (int b = 2; b < 16; b++) begin
         w = 16'h0001 | (16'h0001 << b);
         i_cfsr_ctl.send(w, 16);
         chk("mode_out", {2'h0, w[15:2]}, 16'(mo));
         chk("sleep", 16'(w[15]), 16'(sla));
         chk("soft_reset", 16'(!w[13]), 16'(sra));
         chk("sample", 16'(w[2]), 16'(ssa));
         chk("black", 16'(w[2]), 16'(bsa));
         chk("optical", 16'(!w[3]), 16'(oba));
         sp_sig = 1'b1;
         sp_blk = 1'b0;
         ob_pin = 1'b1;
         repeat (4) @(negedge clk);
         chk("sample_hi", 16'(!w[2]), 16'(ssa));
         chk("black_lo", 16'(w[2]), 16'(bsa));
         chk("optical_hi", 16'(w[3]), 16'(oba));
         sp_sig = 1'b0;
         sp_blk = 1'b1;
         ob_pin = 1'b0;
         repeat (4) @(negedge clk);
         chk("sample_lo", 16'(w[2]), 16'(ssa));
         chk("black_hi", 16'(!w[2]), 16'(bsa));
         chk("optical_lo", 16'(!w[3]), 16'(oba));
         sp_blk = 1'b0;
         repeat (4) @(negedge clk);
      end
      $display("mode test done");
      i_cfsr_ctl.send(16'h0003, 16);
      chk("test_word", 16'h0003, tw);
      chk("clamp_word", 16'hE87E, cw);
      i_cfsr_ctl.send(16'h0001, 15);
      chk("gain_word", 16'h9FFC, gw);
      i_cfsr_ctl.send(16'h1004, 16);
      chk("gain_out", 16'h0401, 16'(go));
      $display("routing test done");
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      chk("words", 16'h0000, gw | mw | cw | tw);
      chk("soft_reset", 16'h0001, 16'(sra));
      $display("reset test done");
      wrap_up();
   end
endmodule
